// ---- rtl/bsd_drive.sv ----
/*
  Six-step drive block: phase port, commutation timer, chopping timer, stop-edge flag, APB slave.
  Assumes one 25 MHz clock, an APB master, and pins from outside that are asynchronous.
*/
// Our own choices: register access over APB and the placing of the registers.
// Contract
// - Output pins read back the stored latch bit.
// - Input pins read back the synchronised pin level.
// - Eight-bit latch is written only by software, never by pins.
// - Direction register sets input or output per pin.
// - Selected edge on stop pin sets the stop flag.
// - Edge-select register chooses rising or falling stop edge.
// - Enable register gates each interrupt source onto the request; here it gates only the stop flag, the timers use their own enables.
// - An event sets its flag bit to one.
// - Flags stay set until software clears them.
// - Writing zero to a flag bit clears it.
// - Sixteen-bit up-counter with selectable clock and clear condition.
// - Counter equal to period compare sets match flag and clears counter.
// - Period compare 4E20 gives a 10 ms step at the prescale chosen; at 25 MHz the /2, /4 and /8 taps give about 1.6, 3.2 or 6.4 ms.
// - Eight-bit chop counter; period constant sets waveform period.
// - Width constant sets high-level width of chop waveform.
// - C8 period with 64 width gives 50 percent duty.
// - Chop waveform appears on its dedicated pin.
// - All driver signals are active high.
// - Chop control selects clock, clear condition and both match enables.
// - Chop status holds both match flags and the output level choices.
// - Match B drives the chop pin low, match A high.
// - Match A clears the chop counter.
// - Port bits 0 to 5 drive U, inverse U, V, inverse V, W, inverse W.
`timescale 1ns/1ps
`default_nettype none
`include "bsd_cfg.svh"

module bsd_drive #(
  parameter int CMT_PERIOD_RST = `BSD_RST_CMT_PERIOD
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_pin_in,
  output logic      [7:0]  phase_drive_outputs,
  output logic      [7:0]  port_pin_oe,
  input  wire logic        stop_request_pin,
  input  wire logic        chop_ext_clock,
  input  wire logic        chop_ext_reset,
  input  wire logic        cmt_ext_clock,
  output logic             chop_wave_pin,
  output logic             irq_request
);

  logic [7:0]  port_output_latch;
  logic [7:0]  port_direction_reg;
  logic [7:0]  stop_edge_select;
  logic [7:0]  irq_enable_reg;
  logic [7:0]  irq_flag_reg;
  logic [7:0]  commutation_timer_control;
  logic [7:0]  commutation_timer_status;
  logic [7:0]  commutation_irq_enable;
  logic [15:0] commutation_counter;
  logic [15:0] period_compare_reg;
  logic [7:0]  chop_timer_control;
  logic [7:0]  chop_clock_select;
  logic [7:0]  chop_timer_status;
  logic [7:0]  chop_counter;
  logic [7:0]  chop_period_constant;
  logic [7:0]  chop_width_constant;

  logic [7:0]  pin_meta;
  logic [7:0]  pin_sync;
  logic [2:0]  ext_meta;
  logic [2:0]  ext_sync;
  logic [2:0]  ext_prev;
  logic [12:0] prescale;
  logic [12:0] prescale_prev;
  logic [12:0] prescale_rise;

  logic        wr_en;
  logic        rd_en;
  logic        stop_event;
  logic        cmt_tick;
  logic        cmt_match;
  logic        chop_tick;
  logic        chop_match_a;
  logic        chop_match_b;
  logic        chop_clear;
  logic [31:0] next_prdata;
  logic        cmt_irq;
  logic        chop_irq;
  logic        addr_bad;

  function automatic logic hit(input logic [11:0] off);
    hit = (paddr == off);
  endfunction

  // Clock-select decode into a divided tick; 0 means stopped
  // Tap vector is an argument so every caller re-evaluates as the prescaler moves
  function automatic logic div_tick(input logic [12:0] rise, input logic [3:0] sel);
    div_tick = (sel == 4'h0) ? 1'b0 : rise[sel - 4'h1];
  endfunction

  function automatic logic [7:0] clr_on_zero(input logic [7:0] cur, input logic [7:0] wdat);
    clr_on_zero = cur & wdat;
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // Pins are asynchronous; two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      ext_meta <= 3'h0;
      ext_sync <= 3'h0;
      ext_prev <= 3'h0;
    end else begin
      pin_meta <= port_pin_in;
      pin_sync <= pin_meta;
      ext_meta <= {cmt_ext_clock, chop_ext_reset, stop_request_pin};
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Stop edge: bit set selects rising, clear selects falling
  always_comb begin
    if (stop_edge_select[`BSD_BIT_STOP])
      stop_event = ext_sync[0] & ~ext_prev[0];
    else
      stop_event = ~ext_sync[0] & ext_prev[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale      <= 13'h0000;
      prescale_prev <= 13'h0000;
    end else begin
      prescale      <= prescale + 13'h0001;
      prescale_prev <= prescale;
    end
  end

  assign prescale_rise = prescale & ~prescale_prev;

  // Commutation clock: 0 = /2, 1 = /4, 2 = /8, 3 = external edge
  always_comb begin
    unique case (commutation_timer_control[1:0])
      2'h0: cmt_tick = div_tick(prescale_rise, 4'h1);
      2'h1: cmt_tick = div_tick(prescale_rise, 4'h2);
      2'h2: cmt_tick = div_tick(prescale_rise, 4'h3);
      default: cmt_tick = ext_sync[2] & ~ext_prev[2];
    endcase
  end

  assign cmt_match = (commutation_counter == period_compare_reg);

  // Chop clock: low three bits pick a prescale tap, select bit 0 takes the chop_ext_reset pin edge
  always_comb begin
    if (chop_clock_select[0])
      chop_tick = ext_sync[1] & ~ext_prev[1];
    else
      chop_tick = div_tick(prescale_rise, {1'b0, chop_timer_control[2:0]});
  end
  assign chop_match_a = (chop_counter == chop_period_constant);
  assign chop_match_b = (chop_counter == chop_width_constant);

  always_comb begin
    unique case (bsd_pkg::bsd_clr_type'(chop_timer_control[4:3]))
      bsd_pkg::BSD_CLR_NONE: chop_clear = 1'b0;
      bsd_pkg::BSD_CLR_A:    chop_clear = chop_match_a;
      bsd_pkg::BSD_CLR_B:    chop_clear = chop_match_b;
      bsd_pkg::BSD_CLR_EXT:  chop_clear = ext_sync[1] & ~ext_prev[1];
    endcase
  end

  // Port registers: latch changes only on a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch  <= `BSD_RST_PORT_LATCH;
      port_direction_reg <= `BSD_RST_PORT_DIR;
    end else if (wr_en) begin
      if (hit(`BSD_OFF_PORT_LATCH))
        port_output_latch <= pwdata[7:0];
      if (hit(`BSD_OFF_PORT_DIR))
        port_direction_reg <= pwdata[7:0];
    end
  end

  // Bits 0..5 are U, inverse U, V, inverse V, W, inverse W; active high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_drive_outputs <= 8'h00;
      port_pin_oe         <= 8'h00;
    end else begin
      phase_drive_outputs <= port_output_latch & port_direction_reg;
      port_pin_oe         <= port_direction_reg;
    end
  end

  // Plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_edge_select          <= 8'h00;
      irq_enable_reg            <= 8'h00;
      commutation_timer_control <= 8'h00;
      commutation_irq_enable    <= 8'h00;
      period_compare_reg        <= 16'(CMT_PERIOD_RST);
      chop_timer_control        <= `BSD_RST_CHOP_CTRL;
      chop_clock_select         <= 8'h00;
      chop_period_constant      <= `BSD_RST_CHOP_PERIOD;
      chop_width_constant       <= `BSD_RST_CHOP_WIDTH;
    end else if (wr_en) begin
      if (hit(`BSD_OFF_STOP_EDGE))   stop_edge_select <= pwdata[7:0];
      if (hit(`BSD_OFF_IRQ_ENABLE))  irq_enable_reg <= pwdata[7:0];
      if (hit(`BSD_OFF_CMT_CTRL))    commutation_timer_control <= pwdata[7:0];
      if (hit(`BSD_OFF_CMT_IRQ_EN))  commutation_irq_enable <= pwdata[7:0];
      if (hit(`BSD_OFF_CMT_PERIOD))  period_compare_reg <= pwdata[15:0];
      if (hit(`BSD_OFF_CHOP_CTRL))   chop_timer_control <= pwdata[7:0];
      if (hit(`BSD_OFF_CHOP_CLKSEL)) chop_clock_select <= pwdata[7:0];
      if (hit(`BSD_OFF_CHOP_PERIOD)) chop_period_constant <= pwdata[7:0];
      if (hit(`BSD_OFF_CHOP_WIDTH))  chop_width_constant <= pwdata[7:0];
    end
  end

  // Stop flag: set wins over a same-cycle clear; no hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 8'h00;
    end else begin
      irq_flag_reg <= (wr_en && hit(`BSD_OFF_IRQ_FLAG))
                      ? clr_on_zero(irq_flag_reg, pwdata[7:0]) : irq_flag_reg;
      if (stop_event)
        irq_flag_reg[`BSD_BIT_STOP] <= 1'b1;
    end
  end

  // Commutation counter; a bus write takes priority over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_counter <= `BSD_RST_CMT_COUNT;
    end else if (wr_en && hit(`BSD_OFF_CMT_COUNT)) begin
      commutation_counter <= pwdata[15:0];
    end else if (cmt_tick) begin
      if (cmt_match && commutation_timer_control[`BSD_BIT_CMT_CLR])
        commutation_counter <= 16'h0000;
      else
        commutation_counter <= commutation_counter + 16'h0001;
    end
  end

  // Match flag set on the counting edge at compare; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commutation_timer_status <= 8'h00;
    end else begin
      commutation_timer_status <= (wr_en && hit(`BSD_OFF_CMT_STATUS))
        ? clr_on_zero(commutation_timer_status, pwdata[7:0]) : commutation_timer_status;
      if (cmt_tick && cmt_match)
        commutation_timer_status[`BSD_BIT_PMATCH] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_counter <= 8'h00;
    end else if (wr_en && hit(`BSD_OFF_CHOP_COUNT)) begin
      chop_counter <= pwdata[7:0];
    end else if (chop_clear && (chop_tick || chop_timer_control[4:3] == 2'h3)) begin
      chop_counter <= 8'h00;
    end else if (chop_tick) begin
      chop_counter <= chop_counter + 8'h01;
    end
  end

  // Chop status: flags in low bits, level choices written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_timer_status <= `BSD_RST_CHOP_STATUS;
    end else begin
      if (wr_en && hit(`BSD_OFF_CHOP_STATUS))
        chop_timer_status <= {pwdata[7:2], chop_timer_status[1:0] & pwdata[1:0]};
      if (chop_tick && chop_match_a)
        chop_timer_status[`BSD_BIT_CHOP_FA] <= 1'b1;
      if (chop_tick && chop_match_b)
        chop_timer_status[`BSD_BIT_CHOP_FB] <= 1'b1;
    end
  end

  function automatic logic apply_out(input logic cur, input logic [1:0] sel);
    unique case (bsd_pkg::bsd_out_type'(sel))
      bsd_pkg::BSD_OUT_KEEP: apply_out = cur;
      bsd_pkg::BSD_OUT_LOW:  apply_out = 1'b0;
      bsd_pkg::BSD_OUT_HIGH: apply_out = 1'b1;
      bsd_pkg::BSD_OUT_TOG:  apply_out = ~cur;
    endcase
  endfunction

  // If both matches hit together, match B's level wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_wave_pin <= 1'b0;
    end else if (chop_tick && chop_match_b) begin
      chop_wave_pin <= apply_out(chop_wave_pin, chop_timer_status[5:4]);
    end else if (chop_tick && chop_match_a) begin
      chop_wave_pin <= apply_out(chop_wave_pin, chop_timer_status[3:2]);
    end
  end

  assign cmt_irq  = commutation_timer_status[`BSD_BIT_PMATCH]
                  & commutation_irq_enable[`BSD_BIT_PMATCH];
  assign chop_irq = (chop_timer_status[`BSD_BIT_CHOP_FA] & chop_timer_control[`BSD_BIT_CHOP_IEA])
                  | (chop_timer_status[`BSD_BIT_CHOP_FB] & chop_timer_control[`BSD_BIT_CHOP_IEB]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= (|(irq_flag_reg & irq_enable_reg)) | cmt_irq | chop_irq;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `BSD_OFF_PORT_LATCH:
        next_prdata[7:0] = (port_direction_reg & port_output_latch)
                         | (~port_direction_reg & pin_sync);
      `BSD_OFF_PORT_DIR:    next_prdata[7:0]  = port_direction_reg;
      `BSD_OFF_STOP_EDGE:   next_prdata[7:0]  = stop_edge_select;
      `BSD_OFF_IRQ_ENABLE:  next_prdata[7:0]  = irq_enable_reg;
      `BSD_OFF_IRQ_FLAG:    next_prdata[7:0]  = irq_flag_reg;
      `BSD_OFF_CMT_CTRL:    next_prdata[7:0]  = commutation_timer_control;
      `BSD_OFF_CMT_STATUS:  next_prdata[7:0]  = commutation_timer_status;
      `BSD_OFF_CMT_IRQ_EN:  next_prdata[7:0]  = commutation_irq_enable;
      `BSD_OFF_CMT_COUNT:   next_prdata[15:0] = commutation_counter;
      `BSD_OFF_CMT_PERIOD:  next_prdata[15:0] = period_compare_reg;
      `BSD_OFF_CHOP_CTRL:   next_prdata[7:0]  = chop_timer_control;
      `BSD_OFF_CHOP_CLKSEL: next_prdata[7:0]  = chop_clock_select;
      `BSD_OFF_CHOP_STATUS: next_prdata[7:0]  = chop_timer_status;
      `BSD_OFF_CHOP_COUNT:  next_prdata[7:0]  = chop_counter;
      `BSD_OFF_CHOP_PERIOD: next_prdata[7:0]  = chop_period_constant;
      `BSD_OFF_CHOP_WIDTH:  next_prdata[7:0]  = chop_width_constant;
      default:              next_prdata       = 32'h0000_0000;
    endcase
  end

  // Anything past the last register or off a word boundary is refused
  assign addr_bad = (paddr > `BSD_OFF_CHOP_WIDTH) || (paddr[1:0] != 2'h0);

  // Read data is captured in setup so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd_en)
        prdata <= next_prdata;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & addr_bad;
    end
  end

endmodule // bsd_drive
`default_nettype wire

// ---- rtl/bsd_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts for the six-step drive block.
  Assumes inclusion once per compilation unit by bare name.
*/
`ifndef BSD_CFG_SVH
`define BSD_CFG_SVH

`define BSD_OFF_PORT_LATCH   12'h000
`define BSD_OFF_PORT_DIR     12'h004
`define BSD_OFF_STOP_EDGE    12'h008
`define BSD_OFF_IRQ_ENABLE   12'h00C
`define BSD_OFF_IRQ_FLAG     12'h010
`define BSD_OFF_CMT_CTRL     12'h014
`define BSD_OFF_CMT_STATUS   12'h018
`define BSD_OFF_CMT_IRQ_EN   12'h01C
`define BSD_OFF_CMT_COUNT    12'h020
`define BSD_OFF_CMT_PERIOD   12'h024
`define BSD_OFF_CHOP_CTRL    12'h028
`define BSD_OFF_CHOP_CLKSEL  12'h02C
`define BSD_OFF_CHOP_STATUS  12'h030
`define BSD_OFF_CHOP_COUNT   12'h034
`define BSD_OFF_CHOP_PERIOD  12'h038
`define BSD_OFF_CHOP_WIDTH   12'h03C

`define BSD_RST_PORT_LATCH   8'h00
`define BSD_RST_PORT_DIR     8'h00
`define BSD_RST_CMT_COUNT    16'hFFFF
`define BSD_RST_CMT_PERIOD   16'h4E20
`define BSD_RST_CHOP_PERIOD  8'hC8
`define BSD_RST_CHOP_WIDTH   8'h64

// Stop-edge, irq enable and irq flag: bit 0 is the stop request source
`define BSD_BIT_STOP         0
// Commutation control: [1:0] clock select, [2] clear on period match
`define BSD_BIT_CMT_CLR      2
// Commutation status/enable: bit 0 period match
`define BSD_BIT_PMATCH       0
// Chop control: [2:0] clock select, [4:3] clear select, [6] irq A en, [7] irq B en
`define BSD_BIT_CHOP_IEA     6
`define BSD_BIT_CHOP_IEB     7
// Chop status: [0] flag A, [1] flag B, [3:2] level at A, [5:4] level at B
`define BSD_BIT_CHOP_FA      0
`define BSD_BIT_CHOP_FB      1
`define BSD_RST_CHOP_STATUS  8'h18
`define BSD_RST_CHOP_CTRL    8'h08

`define BSD_CLK_HZ           25000000
`define BSD_STEP_NS          10000000
`define BSD_CHOP_NS          50000

`endif

// ---- rtl/bsd_pkg.sv ----
/*
  Types for the six-step drive block.
  Assumes the configuration header is compiled alongside.
*/
package bsd_pkg;
  typedef enum logic [1:0] {
    BSD_CLR_NONE  = 2'h0,
    BSD_CLR_A     = 2'h1,
    BSD_CLR_B     = 2'h2,
    BSD_CLR_EXT   = 2'h3
  } bsd_clr_type;

  typedef enum logic [1:0] {
    BSD_OUT_KEEP = 2'h0,
    BSD_OUT_LOW  = 2'h1,
    BSD_OUT_HIGH = 2'h2,
    BSD_OUT_TOG  = 2'h3
  } bsd_out_type;
endpackage

// ---- verification/bsd_drive_props.sv ----
/*
  Port assertions for the six-step drive block.
  Assumes a bind onto bsd_drive from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_drive_props #(
  parameter int CMT_PERIOD_RST = 16'h4E20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_pin_in,
  input wire logic [7:0]  phase_drive_outputs,
  input wire logic [7:0]  port_pin_oe,
  input wire logic        stop_request_pin,
  input wire logic        chop_ext_clock,
  input wire logic        chop_ext_reset,
  input wire logic        cmt_ext_clock,
  input wire logic        chop_wave_pin,
  input wire logic        irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states, so every access phase is also the answer cycle
  wire acc_wr;
  assign acc_wr = psel && penable && pwrite;

  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (psel && !penable && (paddr > 12'h03C || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("bad address not refused");
  a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returns data");
  a_phase_masked: assert property ((phase_drive_outputs & ~port_pin_oe) == 8'h00)
    else $error("input pin driven");
  // Latch lands on the write edge, the registered pins one edge later
  a_latch_echo: assert property (acc_wr && paddr == 12'h000
    |-> ##2 phase_drive_outputs == ($past(pwdata[7:0], 2) & port_pin_oe))
    else $error("latch not on pins");
  a_phase_cause: assert property ($changed(phase_drive_outputs)
    |-> $past(acc_wr && paddr[11:3] == 9'h000, 2)) else $error("phase change without write");
  // Request is registered from the flags, so a write shows one edge late
  a_flag_hold: assert property (irq_request && !$past(acc_wr) |=> irq_request)
    else $error("request dropped without write");
endmodule // bsd_drive_props
`default_nettype wire

// ---- verification/bsd_driver_stage.sv ----
/*
  Motor driver stage with the external AND gates and the port pin wiring.
  Assumes the drive block's phase, enable and chop outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_driver_stage (
  input  wire logic [7:0] phase_drive_outputs,
  input  wire logic [7:0] port_pin_oe,
  input  wire logic       chop_wave_pin,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] port_pin_in,
  output logic      [5:0] driver_gate
);
  // Released pins show the outside level, never the last driven one
  assign port_pin_in = (port_pin_oe & phase_drive_outputs) | (~port_pin_oe & ext_level);
  // Only inverse phases are chopped; all gate inputs active high
  assign driver_gate = {phase_drive_outputs[5] & chop_wave_pin, phase_drive_outputs[4],
    phase_drive_outputs[3] & chop_wave_pin, phase_drive_outputs[2],
    phase_drive_outputs[1] & chop_wave_pin, phase_drive_outputs[0]};
endmodule // bsd_driver_stage
`default_nettype wire

// ---- verification/bsd_drive_bench.sv ----
/*
  Self-checking bench for the six-step drive block.
  Assumes the driver stage model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module bsd_drive_bench;
  // Short commutation period keeps the run brief
  localparam logic [15:0] PER = 16'h0020;
  localparam logic [7:0] PAT [6] = '{8'h09, 8'h21, 8'h24, 8'h06, 8'h12, 8'h18};
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic e;} bsd_row_type;
  bsd_row_type rows [17] = '{
    '{12'h004, 1'b0, 32'h00, 1'b0}, '{12'h000, 1'b0, 32'h5A, 1'b0},
    '{12'h008, 1'b0, 32'h00, 1'b0}, '{12'h00C, 1'b0, 32'h00, 1'b0},
    '{12'h010, 1'b0, 32'h00, 1'b0}, '{12'h024, 1'b0, {16'h0, PER}, 1'b0},
    '{12'h028, 1'b0, 32'h08, 1'b0}, '{12'h030, 1'b0, 32'h18, 1'b0},
    '{12'h038, 1'b0, 32'hC8, 1'b0}, '{12'h03C, 1'b0, 32'h64, 1'b0},
    '{12'h004, 1'b1, 32'hFF, 1'b0}, '{12'h000, 1'b1, 32'hA5, 1'b0},
    '{12'h000, 1'b0, 32'hA5, 1'b0}, '{12'h004, 1'b1, 32'h0F, 1'b0},
    '{12'h040, 1'b0, 32'h00, 1'b1}, '{12'h002, 1'b1, 32'h77, 1'b1},
    '{12'h000, 1'b0, 32'h55, 1'b0}};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        stop_request_pin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd_v;
  logic [7:0]  ext_level = 8'h5A;
  logic        rd_e;
  wire  [31:0] prdata;
  wire  [7:0]  port_pin_in, phase_drive_outputs, port_pin_oe;
  wire  [5:0]  driver_gate;
  wire         pready, pslverr, chop_wave_pin, irq_request;
  int          num_errors = 0, tests_run = 0, cyc = 0, t0, t1, t2, tp;

  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // Whole run needs about 1400 cycles
  always @(posedge pclk) if (cyc == 8000) begin
    num_errors++;
    summarize();
  end

  bsd_drive #(.CMT_PERIOD_RST(PER)) u_bsd_drive (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pin_in(port_pin_in), .phase_drive_outputs(phase_drive_outputs),
    .port_pin_oe(port_pin_oe), .stop_request_pin(stop_request_pin),
    .chop_ext_clock(1'b0), .chop_ext_reset(1'b0), .cmt_ext_clock(1'b0),
    .chop_wave_pin(chop_wave_pin), .irq_request(irq_request));
  bsd_driver_stage u_bsd_driver_stage (
    .phase_drive_outputs(phase_drive_outputs), .port_pin_oe(port_pin_oe),
    .chop_wave_pin(chop_wave_pin), .ext_level(ext_level), .port_pin_in(port_pin_in),
    .driver_gate(driver_gate));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Called just after an edge; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd_v, x);
  endtask

  task automatic waitv(input logic s, input logic v, output int t);
    do @(posedge pclk); while ((s ? chop_wave_pin : irq_request) !== v);
    t = cyc;
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd_e, rows[i].e);
      if (!rows[i].w) chk(rd_v, rows[i].d);
    end
    wr(12'h004, 32'h3F);
    $display("register table done");
    wr(12'h008, 32'h1);
    wr(12'h00C, 32'h1);
    stop_request_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h010, 32'h1);
    chk(irq_request, 1'b1);
    repeat (20) @(posedge pclk);
    rd(12'h010, 32'h1);
    wr(12'h010, 32'h0);
    rd(12'h010, 32'h0);
    chk(irq_request, 1'b0);
    wr(12'h008, 32'h0);
    stop_request_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(12'h010, 32'h1);
    wr(12'h00C, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq_request, 1'b0);
    wr(12'h010, 32'h0);
    $display("stop request test done");
    wr(12'h014, 32'h4);
    wr(12'h020, 32'h0);
    wr(12'h018, 32'h0);
    wr(12'h01C, 32'h1);
    for (int k = 0; k < 7; k++) begin
      waitv(1'b0, 1'b1, t1);
      if (k > 0) chk(t1 - tp, (PER + 1) * 2);
      tp = t1;
      wr(12'h018, 32'h0);
      wr(12'h000, {24'h0, PAT[k % 6]});
      // Phase pins follow the latch one edge after the write
      @(posedge pclk);
      chk(phase_drive_outputs, PAT[k % 6]);
    end
    wr(12'h01C, 32'h0);
    $display("commutation test done");
    wr(12'h028, 32'h09);
    waitv(1'b1, 1'b0, t0);
    waitv(1'b1, 1'b1, t0);
    waitv(1'b1, 1'b0, t1);
    waitv(1'b1, 1'b1, t2);
    chk(t1 - t0, (8'h64 + 1) * 2);
    chk(t2 - t0, (8'hC8 + 1) * 2);
    $display("chop test done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(phase_drive_outputs, 8'h00);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h004, 32'h0);
    wr(12'h004, 32'hFF);
    rd(12'h000, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule // bsd_drive_bench

bind bsd_drive bsd_drive_props #(.CMT_PERIOD_RST(CMT_PERIOD_RST)) u_bsd_drive_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_pin_in(port_pin_in), .phase_drive_outputs(phase_drive_outputs),
  .port_pin_oe(port_pin_oe), .stop_request_pin(stop_request_pin),
  .chop_ext_clock(chop_ext_clock), .chop_ext_reset(chop_ext_reset),
  .cmt_ext_clock(cmt_ext_clock), .chop_wave_pin(chop_wave_pin), .irq_request(irq_request));
`default_nettype wire
